// >>> i2cbe_defs.svh
`ifndef I2CBE_DEFS_SVH
`define I2CBE_DEFS_SVH

// ==========================================================
// timing
`define I2CBE_CLK_PERIOD_NS 10
`define I2CBE_INIT_TIME_US 550
`define I2CBE_INIT_CYCLES ((`I2CBE_INIT_TIME_US * 1000) / `I2CBE_CLK_PERIOD_NS)
`define I2CBE_RST_PULSE_CYCLES 4
`define I2CBE_BITS_PER_BYTE 9

// ==========================================================
// status codes and control layout
`define I2CBE_STAT_IDLE 8'hF8
`define I2CBE_STAT_BUS_ERR 8'h00
`define I2CBE_CTRL_RESET 8'h00
`define I2CBE_CTRL_ACK_BIT 2
`define I2CBE_CTRL_INT_BIT 3
`define I2CBE_CTRL_OSC_BIT 5
`define I2CBE_SEL_CTRL 1'b0
`define I2CBE_SEL_STAT 1'b1
`endif

// >>> i2cbe_pkg.sv
package i2cbe_pkg;
  typedef enum logic [1:0] {INIT_OSC, INIT_REGS, INIT_DONE} i2cbe_init_e;
  typedef logic [7:0] i2cbe_byte_t;
  typedef logic [3:0] i2cbe_bitcnt_t;
endpackage

// >>> i2cbe_link_mon.sv
`timescale 1ns/1ns
`include "i2cbe_defs.svh"
module i2cbe_link_mon
  import i2cbe_pkg::*;
(
  input wire logic linkClk,
  input wire logic rst,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic involvedLvl,
  input wire logic ackEnLvl,
  input wire logic sdaLowLvl,
  input wire logic sclLowLvl,
  input wire logic clrToggle,
  output logic sclOut,
  output logic sclOe,
  output logic sdaOut,
  output logic sdaOe,
  output logic errToggle,
  output logic busy
);
  // ==========================================================
  // reset and synchronisers
  logic linkRstMeta_q, linkRst_q;
  logic [6:0] syncMeta_q, sync_q;
  logic sclPrev_q, sdaPrev_q, clrSeen_q, frame_q, errLatched_q, ackSlot_q;
  i2cbe_bitcnt_t bitCnt_q;

  always_ff @(posedge linkClk or posedge rst) begin
    if (rst) begin
      linkRstMeta_q <= 1'b1;
      linkRst_q <= 1'b1;
    end else begin
      linkRstMeta_q <= 1'b0;
      linkRst_q <= linkRstMeta_q;
    end
  end

  always_ff @(posedge linkClk or posedge linkRst_q) begin
    if (linkRst_q) begin
      syncMeta_q <= 7'h03;
      sync_q <= 7'h03;
    end else begin
      syncMeta_q <= {clrToggle, sclLowLvl, sdaLowLvl, ackEnLvl, involvedLvl, sdaIn, sclIn};
      sync_q <= syncMeta_q;
    end
  end

  // ==========================================================
  // condition decode
  wire sclNow = sync_q[0];
  wire sdaNow = sync_q[1];
  wire involved = sync_q[2];
  wire ackEn = sync_q[3];
  wire clrEvent = sync_q[6] ^ clrSeen_q;
  wire sclRise = sclNow & ~sclPrev_q;
  wire sclFall = ~sclNow & sclPrev_q;
  wire startCond = sclNow & sclPrev_q & sdaPrev_q & ~sdaNow;
  wire stopCond = sclNow & sclPrev_q & ~sdaPrev_q & sdaNow;
  // a stop or repeated start can only sit in the first clock of a byte
  wire legalPos = ~frame_q | (bitCnt_q == 4'h1);
  wire illegalCond = (startCond | stopCond) & ~legalPos;
  wire busErrHit = illegalCond & involved & ~errLatched_q;
  wire sdaWant = ackSlot_q ? ackEn : sync_q[4];
  wire sdaOeD = (errLatched_q | busErrHit) ? 1'b0 : (sclNow ? sdaOe : sdaWant);
  wire sclOeD = (errLatched_q | busErrHit) ? 1'b0 : sync_q[5];

  // ==========================================================
  // frame tracking; bytes are never counted, so frames have no length limit
  always_ff @(posedge linkClk or posedge linkRst_q) begin
    if (linkRst_q) begin
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
      clrSeen_q <= 1'b0;
      frame_q <= 1'b0;
      bitCnt_q <= 4'h0;
      ackSlot_q <= 1'b0;
      errLatched_q <= 1'b0;
      errToggle <= 1'b0;
      busy <= 1'b0;
      sdaOe <= 1'b0;
      sclOe <= 1'b0;
      sdaOut <= 1'b0;
      sclOut <= 1'b0;
    end else begin
      sclPrev_q <= sclNow;
      sdaPrev_q <= sdaNow;
      clrSeen_q <= sync_q[6];
      if (startCond) begin
        frame_q <= 1'b1;
        bitCnt_q <= 4'h0;
      end else if (stopCond) begin
        frame_q <= 1'b0;
        bitCnt_q <= 4'h0;
      end else if (sclRise && frame_q) begin
        bitCnt_q <= (bitCnt_q == 4'(`I2CBE_BITS_PER_BYTE)) ? 4'h1 : bitCnt_q + 4'h1;
      end
      if (startCond || stopCond) begin
        ackSlot_q <= 1'b0;
      end else if (sclFall && bitCnt_q == 4'(`I2CBE_BITS_PER_BYTE - 1)) begin
        ackSlot_q <= 1'b1;
      end else if (sclFall) begin
        ackSlot_q <= 1'b0;
      end
      if (busErrHit) begin
        errLatched_q <= 1'b1;
        errToggle <= ~errToggle;
      end else if (clrEvent) begin
        errLatched_q <= 1'b0;
      end
      busy <= frame_q;
      sdaOe <= sdaOeD;
      sclOe <= sclOeD;
    end
  end

  // ==========================================================
  // checks
  property p_link_release;
    @(posedge linkClk) disable iff (linkRst_q) busErrHit |=> !sdaOe && !sclOe && errLatched_q;
  endproperty
  a_link_release: assert property (p_link_release) else $error("lines not released");

  property p_link_ignore;
    @(posedge linkClk) disable iff (linkRst_q) illegalCond && !involved |=> $stable(errToggle);
  endproperty
  a_link_ignore: assert property (p_link_ignore) else $error("error taken while idle");

  property p_link_stable;
    @(posedge linkClk) disable iff (linkRst_q)
      sclNow && !errLatched_q && !busErrHit |=> $stable(sdaOe);
  endproperty
  a_link_stable: assert property (p_link_stable) else $error("data moved in clock high");

  property p_link_wrap;
    @(posedge linkClk) disable iff (linkRst_q)
      sclRise && frame_q && !startCond && !stopCond && bitCnt_q == 4'h9 |=> bitCnt_q == 4'h1;
  endproperty
  a_link_wrap: assert property (p_link_wrap) else $error("bit count wrap wrong");

  property p_link_start;
    @(posedge linkClk) disable iff (linkRst_q) startCond |=> frame_q ##1 busy;
  endproperty
  a_link_start: assert property (p_link_start) else $error("start not seen");

  property p_link_ack;
    @(posedge linkClk) disable iff (linkRst_q)
      ackSlot_q && ackEn && !sclNow && !errLatched_q && !busErrHit |=> sdaOe;
  endproperty
  a_link_ack: assert property (p_link_ack) else $error("ack not driven");

  property p_link_err_pos;
    @(posedge linkClk) disable iff (linkRst_q)
      frame_q && bitCnt_q > 4'h1 && stopCond && involved && !errLatched_q |=> errLatched_q;
  endproperty
  a_link_err_pos: assert property (p_link_err_pos) else $error("stop mid byte missed");
endmodule

// >>> i2cbe_ctrl.sv
`timescale 1ns/1ns
`include "i2cbe_defs.svh"
module i2cbe_ctrl
  import i2cbe_pkg::*;
#(
  parameter int unsigned InitCycles = `I2CBE_INIT_CYCLES,
  parameter int unsigned RstPulseCycles = `I2CBE_RST_PULSE_CYCLES
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic linkClk,
  input wire logic rstPinN,
  input wire logic swReset,
  input wire logic rdStrobe,
  input wire logic rdSel,
  input wire logic wrStrobe,
  input wire logic wrSel,
  input wire logic [7:0] wrData,
  input wire logic involved,
  input wire logic sdaDriveLow,
  input wire logic sclDriveLow,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sclOut,
  output logic sclOe,
  output logic sdaOut,
  output logic sdaOe,
  output logic [7:0] rdData,
  output logic rdValid,
  output logic intFlag,
  output logic busBusy,
  output logic ready
);
  localparam int CntW = $clog2(InitCycles + 1);
  localparam int RstW = $clog2(RstPulseCycles + 1);

  // ==========================================================
  // state
  i2cbe_init_e initState_q, initState_d;
  logic [CntW-1:0] initCnt_q;
  logic oscEn_q;
  i2cbe_byte_t ctrl_q, status_q;
  logic [RstW-1:0] rstCnt_q;
  logic rstPinMeta_q, rstPin_q, rstArmed_q;
  logic errMeta_q, errSync_q, errSeen_q;
  logic busyMeta_q;
  logic clrToggle_q;
  logic linkErrToggle, linkBusy;

  // ==========================================================
  // decode
  wire initBusy = (initState_q != INIT_DONE);
  wire initLast = (initCnt_q == CntW'(InitCycles - 2));
  wire hwResetHit = rstArmed_q && (rstCnt_q == RstW'(RstPulseCycles));
  wire softClear = hwResetHit | swReset;
  wire errPulse = errSync_q ^ errSeen_q;
  wire ctrlWrite = wrStrobe && !initBusy && (wrSel == `I2CBE_SEL_CTRL);
  wire [7:0] ctrlView = ctrlWord(ctrl_q, oscEn_q, intFlag);
  wire [7:0] rdWord = (rdSel == `I2CBE_SEL_STAT) ? status_q : ctrlView;

  // the oscillator and interrupt flags live outside the control byte
  function automatic logic [7:0] ctrlWord(input logic [7:0] c, input logic osc, input logic irq);
    logic [7:0] w;
    w = c;
    w[`I2CBE_CTRL_OSC_BIT] = osc;
    w[`I2CBE_CTRL_INT_BIT] = irq;
    return w;
  endfunction

  // ==========================================================
  // power-up initialisation; only the power-on reset restarts it
  always_comb begin
    initState_d = initState_q;
    unique case (initState_q)
      INIT_OSC: begin
        initState_d = INIT_REGS;
      end
      INIT_REGS: begin
        if (initLast) begin
          initState_d = INIT_DONE;
        end
      end
      INIT_DONE: begin
        initState_d = INIT_DONE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      initState_q <= INIT_OSC;
      initCnt_q <= '0;
      oscEn_q <= 1'b0;
      ready <= 1'b0;
    end else begin
      initState_q <= initState_d;
      initCnt_q <= (initState_q == INIT_REGS) ? initCnt_q + CntW'(1) : '0;
      oscEn_q <= (initState_d == INIT_REGS);
      ready <= (initState_d == INIT_DONE);
    end
  end

  // ==========================================================
  // reset pin: synchronised, must stay low for the pulse width
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rstPinMeta_q <= 1'b1;
      rstPin_q <= 1'b1;
      rstCnt_q <= '0;
      rstArmed_q <= 1'b1;
    end else begin
      rstPinMeta_q <= rstPinN;
      rstPin_q <= rstPinMeta_q;
      if (rstPin_q) begin
        rstCnt_q <= '0;
        rstArmed_q <= 1'b1;
      end else if (hwResetHit) begin
        rstArmed_q <= 1'b0; // one clear per low pulse
      end else begin
        rstCnt_q <= rstCnt_q + RstW'(1);
      end
    end
  end

  // ==========================================================
  // error event crossing and clear toggle towards the link
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      errMeta_q <= 1'b0;
      errSync_q <= 1'b0;
      errSeen_q <= 1'b0;
      busyMeta_q <= 1'b0;
      busBusy <= 1'b0;
      clrToggle_q <= 1'b0;
    end else begin
      errMeta_q <= linkErrToggle;
      errSync_q <= errMeta_q;
      errSeen_q <= errSync_q;
      busyMeta_q <= linkBusy;
      busBusy <= busyMeta_q;
      if (softClear) begin
        clrToggle_q <= ~clrToggle_q;
      end
    end
  end

  // ==========================================================
  // control, status and interrupt flag
  // an error landing with a reset wins, so the event is never lost
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= `I2CBE_CTRL_RESET;
      status_q <= `I2CBE_STAT_IDLE;
      intFlag <= 1'b0;
    end else begin
      if (errPulse) begin
        status_q <= `I2CBE_STAT_BUS_ERR;
        intFlag <= 1'b1;
      end else if (softClear) begin
        status_q <= `I2CBE_STAT_IDLE;
        intFlag <= 1'b0;
      end
      if (softClear || initState_q == INIT_REGS) begin
        ctrl_q <= `I2CBE_CTRL_RESET;
      end else if (ctrlWrite) begin
        ctrl_q <= wrData;
      end
    end
  end

  // ==========================================================
  // host reads, allowed at any time
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdData <= 8'h00;
      rdValid <= 1'b0;
    end else begin
      rdValid <= rdStrobe;
      if (rdStrobe) begin
        rdData <= rdWord;
      end
    end
  end

  // ==========================================================
  // link side
  i2cbe_link_mon u_link (
    .linkClk(linkClk),
    .rst(rst),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .involvedLvl(involved),
    .ackEnLvl(ctrl_q[`I2CBE_CTRL_ACK_BIT]),
    .sdaLowLvl(sdaDriveLow),
    .sclLowLvl(sclDriveLow),
    .clrToggle(clrToggle_q),
    .sclOut(sclOut),
    .sclOe(sclOe),
    .sdaOut(sdaOut),
    .sdaOe(sdaOe),
    .errToggle(linkErrToggle),
    .busy(linkBusy)
  );

  // ==========================================================
  // checks
  sequence s_init_start;
    initState_q == INIT_OSC;
  endsequence

  sequence s_init_run;
    initState_q == INIT_REGS && oscEn_q;
  endsequence

  property p_init_seq;
    @(posedge clk) disable iff (rst) s_init_start |=> s_init_run;
  endproperty
  a_init_seq: assert property (p_init_seq) else $error("init did not raise osc flag");

  property p_init_bound;
    @(posedge clk) disable iff (rst) initBusy |-> initCnt_q < CntW'(InitCycles);
  endproperty
  a_init_bound: assert property (p_init_bound) else $error("init ran too long");

  property p_osc_view;
    @(posedge clk) disable iff (rst) rdStrobe && rdSel == `I2CBE_SEL_CTRL
      |=> rdValid && rdData[`I2CBE_CTRL_OSC_BIT] == $past(oscEn_q);
  endproperty
  a_osc_view: assert property (p_osc_view) else $error("osc flag misreported");

  property p_osc_off;
    @(posedge clk) disable iff (rst) ready |-> !oscEn_q;
  endproperty
  a_osc_off: assert property (p_osc_off) else $error("osc flag high after init");

  property p_err_status;
    @(posedge clk) disable iff (rst) errPulse |=> status_q == `I2CBE_STAT_BUS_ERR && intFlag;
  endproperty
  a_err_status: assert property (p_err_status) else $error("error status not loaded");

  property p_err_hold;
    @(posedge clk) disable iff (rst) intFlag && status_q == `I2CBE_STAT_BUS_ERR && !softClear
      |=> intFlag;
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error flag dropped early");

  property p_reset_idle;
    @(posedge clk) disable iff (rst) softClear && !errPulse
      |=> status_q == `I2CBE_STAT_IDLE && !intFlag;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("reset not idle");

  property p_no_reinit;
    @(posedge clk) disable iff (rst) softClear && ready |=> ready && !oscEn_q;
  endproperty
  a_no_reinit: assert property (p_no_reinit) else $error("reset restarted init");

  property p_write_block;
    @(posedge clk) disable iff (rst) wrStrobe && initState_q == INIT_DONE && !softClear
      && wrSel == `I2CBE_SEL_CTRL |=> ctrl_q == $past(wrData);
  endproperty
  a_write_block: assert property (p_write_block) else $error("control write lost");

  property p_pin_pulse;
    @(posedge clk) disable iff (rst) hwResetHit |=> status_q == `I2CBE_STAT_IDLE || intFlag;
  endproperty
  a_pin_pulse: assert property (p_pin_pulse) else $error("pin reset ignored");
endmodule

// >>> i2cbe_bus_model.sv
`timescale 1ns/1ns
// ==========================================================
// far-side bus master: open drain, pull-up makes a released line high
module i2cbe_bus_model (
  input wire logic linkClk,
  input wire logic sdaLine,
  input wire logic busBusy,
  output logic sclLow,
  output logic sdaLow
);
  int unsigned quarter = 4;

  initial begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
  end

  task automatic tick();
    repeat (quarter) @(posedge linkClk);
  endtask

  task automatic startCond();
    wait (busBusy === 1'b0);
    @(posedge linkClk);
    sdaLow <= 1'b1;
    tick();
    sclLow <= 1'b1;
    tick();
  endtask

  // data only moves while the clock is low
  task automatic sendBit(input logic b, output logic s);
    sdaLow <= !b;
    tick();
    sclLow <= 1'b0;
    tick();
    s = sdaLine;
    tick();
    sclLow <= 1'b1;
    tick();
  endtask

  task automatic sendByte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      sendBit(d[i], s);
    end
    sendBit(1'b1, ack);
  endtask

  task automatic stopCond();
    sdaLow <= 1'b1;
    tick();
    sclLow <= 1'b0;
    tick();
    sdaLow <= 1'b0;
    tick();
  endtask
endmodule

// >>> tb_i2c_bus_error_and_init_control.sv
`timescale 1ns/1ns
`include "i2cbe_defs.svh"
module tb_i2c_bus_error_and_init_control
  import i2cbe_pkg::*;
;
  localparam int unsigned InitCycles = 20;
  localparam int unsigned RstPulseCycles = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic linkClk = 1'b0;
  logic rstPinN = 1'b1;
  logic swReset = 1'b0;
  logic rdStrobe = 1'b0;
  logic rdSel = 1'b0;
  logic wrStrobe = 1'b0;
  logic wrSel = 1'b0;
  logic [7:0] wrData = 8'h00;
  logic involved = 1'b0;
  logic sdaDriveLow = 1'b0;
  logic sclDriveLow = 1'b0;
  logic sclOut, sclOe, sdaOut, sdaOe, rdValid, intFlag, busBusy, ready;
  logic [7:0] rdData;
  logic mSclLow, mSdaLow, sclLine, sdaLine, ack;
  i2cbe_byte_t r;
  int fails = 0;
  int cmp_count = 0;
  int cnt;
  int seed;

  // wired-and of both parties, pull-up when released
  assign sclLine = !(sclOe | mSclLow);
  assign sdaLine = !(sdaOe | mSdaLow);

  i2cbe_ctrl #(.InitCycles(InitCycles), .RstPulseCycles(RstPulseCycles)) uut (
    .clk(clk), .rst(rst), .linkClk(linkClk), .rstPinN(rstPinN), .swReset(swReset),
    .rdStrobe(rdStrobe), .rdSel(rdSel), .wrStrobe(wrStrobe), .wrSel(wrSel),
    .wrData(wrData), .involved(involved), .sdaDriveLow(sdaDriveLow),
    .sclDriveLow(sclDriveLow), .sclIn(sclLine), .sdaIn(sdaLine), .sclOut(sclOut),
    .sclOe(sclOe), .sdaOut(sdaOut), .sdaOe(sdaOe), .rdData(rdData), .rdValid(rdValid),
    .intFlag(intFlag), .busBusy(busBusy), .ready(ready)
  );

  i2cbe_bus_model model (
    .linkClk(linkClk), .sdaLine(sdaLine), .busBusy(busBusy),
    .sclLow(mSclLow), .sdaLow(mSdaLow)
  );

  always #5 clk = ~clk;

  initial begin
    #4;
    forever #15 linkClk = ~linkClk;
  end

  // ==========================================================
  // helpers
  function automatic logic [7:0] ctrlExp(input logic osc, input logic intf, input logic ak);
    logic [7:0] v;
    v = `I2CBE_CTRL_RESET;
    v[`I2CBE_CTRL_OSC_BIT] = osc;
    v[`I2CBE_CTRL_INT_BIT] = intf;
    v[`I2CBE_CTRL_ACK_BIT] = ak;
    return v;
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic readReg(input logic sel, output logic [7:0] d);
    @(negedge clk);
    rdStrobe = 1'b1;
    rdSel = sel;
    @(negedge clk);
    rdStrobe = 1'b0;
    // rdValid stands for one cycle only, so look at it before the next edge
    chk({7'h00, rdValid}, 8'h01);
    d = rdData;
  endtask

  task automatic writeCtrl(input logic [7:0] d);
    @(negedge clk);
    chk({7'h00, ready}, 8'h01);
    wrStrobe = 1'b1;
    wrSel = `I2CBE_SEL_CTRL;
    wrData = d;
    @(negedge clk);
    wrStrobe = 1'b0;
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #300000;
    fails++;
    final_report();
  end

  // ==========================================================
  // tests
  initial begin
    seed = $urandom(32'h2886);
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    readReg(`I2CBE_SEL_CTRL, r);
    chk(r, ctrlExp(1'b1, 1'b0, 1'b0));
    cnt = 2;
    while (ready !== 1'b1 && cnt < 200) begin
      @(negedge clk);
      cnt++;
    end
    chk(8'(cnt), 8'(InitCycles));
    // a write aimed at the status side must leave the control byte alone
    @(negedge clk);
    wrStrobe = 1'b1;
    wrSel = `I2CBE_SEL_STAT;
    wrData = 8'h04;
    @(negedge clk);
    wrStrobe = 1'b0;
    wrSel = `I2CBE_SEL_CTRL;
    readReg(`I2CBE_SEL_CTRL, r);
    chk(r, ctrlExp(1'b0, 1'b0, 1'b0));
    readReg(`I2CBE_SEL_STAT, r);
    chk(r, `I2CBE_STAT_IDLE);
    $display("test init done");

    involved = 1'b1;
    for (int k = 0; k < 4; k++) begin
      writeCtrl(ctrlExp(1'b0, 1'b0, k[0]));
      readReg(`I2CBE_SEL_CTRL, r);
      chk(r, ctrlExp(1'b0, 1'b0, k[0]));
      model.startCond();
      chk({7'h00, busBusy}, 8'h01);
      for (int b = 0; b < 1 + k + ($urandom % 3); b++) begin
        model.sendByte(8'($urandom), ack);
        chk({7'h00, ack}, {7'h00, !k[0]});
      end
      model.stopCond();
      repeat (20) @(negedge clk);
      chk({6'h00, busBusy, intFlag}, 8'h00);
    end
    $display("test transfers done");

    involved = 1'b0;
    model.startCond();
    for (int i = 0; i < 3; i++) begin
      model.sendBit(1'($urandom), ack);
    end
    model.stopCond();
    repeat (20) @(negedge clk);
    chk({7'h00, intFlag}, 8'h00);
    readReg(`I2CBE_SEL_STAT, r);
    chk(r, `I2CBE_STAT_IDLE);
    $display("test uninvolved done");

    involved = 1'b1;
    for (int j = 0; j < 2; j++) begin
      writeCtrl(ctrlExp(1'b0, 1'b0, 1'b1));
      model.startCond();
      for (int i = 0; i < 3; i++) begin
        model.sendBit(1'($urandom), ack);
      end
      model.stopCond();
      repeat (10) @(negedge clk);
      chk({3'h0, sclOut, sdaOut, intFlag, sclOe, sdaOe}, 8'h04);
      readReg(`I2CBE_SEL_STAT, r);
      chk(r, `I2CBE_STAT_BUS_ERR);
      repeat (50) @(negedge clk);
      chk({7'h00, intFlag}, 8'h01);
      if (j == 0) begin
        swReset = 1'b1;
        @(negedge clk);
        swReset = 1'b0;
      end else begin
        rstPinN = 1'b0;
        repeat (RstPulseCycles + 4) @(negedge clk);
        rstPinN = 1'b1;
      end
      repeat (10) @(negedge clk);
      chk({6'h00, intFlag, ready}, 8'h01);
      readReg(`I2CBE_SEL_STAT, r);
      chk(r, `I2CBE_STAT_IDLE);
      readReg(`I2CBE_SEL_CTRL, r);
      chk(r, ctrlExp(1'b0, 1'b0, 1'b0));
    end
    $display("test bus error done");
    final_report();
  end
endmodule
